// file: eoc_top.sv
module eoc_top (
    input  wire logic                                  sys_clk,
    input  wire logic                                  rst,
    input  wire eoc_pkg::eoc_req_s                     regReq,
    output logic      [eoc_pkg::DATA_W-1:0]            rdata,
    input  wire logic [eoc_pkg::NUM_SYNC_SRC-1:0]      syncIn,
    input  wire logic [1:0]                            extClkPin,
    output logic      [eoc_pkg::NUM_UNITS-1:0]         cmpOut,
    output logic      [eoc_pkg::NUM_UNITS-1:0]         cmpEvent
);
    localparam int N = eoc_pkg::NUM_UNITS;
    localparam int W = eoc_pkg::CNT_W;

    logic [eoc_pkg::NUM_CLK_SRC-1:0] srcTick;
    eoc_pkg::eoc_cfg_s               cfg_reg   [N];
    eoc_pkg::eoc_cfg_s               cfgEff    [N];
    logic [W-1:0]                    cnt_reg   [N];
    logic [W-1:0]                    pri_reg   [N];
    logic [W-1:0]                    sec_reg   [N];
    logic [N-1:0]                    out_reg;
    logic [N-1:0]                    evt_reg;
    logic [N-1:0]                    done_reg;
    logic [N-1:0]                    released_reg;
    logic [N-1:0]                    pairOn;
    logic [N-1:0]                    follower;
    logic [N-1:0]                    tickSel;
    logic [N-1:0]                    sEvt;
    logic [N-1:0]                    syncM;
    logic [N-1:0]                    trigM;
    logic [N-1:0]                    en;
    logic [N-1:0]                    step;
    logic [N-1:0]                    restart;
    logic [N-1:0]                    carry;
    logic [N-1:0]                    mPri;
    logic [N-1:0]                    mSec;
    logic [N-1:0]                    unitHit;
    logic [eoc_pkg::DATA_W-1:0]      rdata_next;
    logic [eoc_pkg::DATA_W-1:0]      rdata_reg;

    logic [3:0] selUnit;
    logic [2:0] selReg;
    assign selUnit = regReq.addr[eoc_pkg::ADDR_W-1:eoc_pkg::UNIT_LSB];
    assign selReg  = regReq.addr[eoc_pkg::UNIT_LSB-1:0];

    eoc_clock_sources u_clk (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .extClkPin (extClkPin),
        .srcTick   (srcTick)
    );

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_unit
            assign unitHit[i] = (selUnit == 4'(i));

            // pairing: odd unit (even index) is low half, next is high
            if (i % 2 == 1) begin : g_hi
                assign pairOn[i]   = cfg_reg[i-1].casc & cfg_reg[i].casc;
                assign follower[i] = pairOn[i];
                assign cfgEff[i]   = pairOn[i] ? cfg_reg[i-1] : cfg_reg[i];
                assign step[i]     = pairOn[i] ? carry[i-1] : (tickSel[i] & en[i]);
                assign restart[i]  = pairOn[i] ? restart[i-1]
                                   : ((syncM[i] & sEvt[i])
                                      | ((cfgEff[i].mode == eoc_pkg::MODE_PWM) & step[i] & mSec[i]));
                assign mPri[i]     = (cnt_reg[i] == pri_reg[i]);
                assign mSec[i]     = (cnt_reg[i] == sec_reg[i]);
            end else begin : g_lo
                if (i + 1 < N) begin : g_pair
                    assign pairOn[i] = cfg_reg[i].casc & cfg_reg[i+1].casc;
                    assign mPri[i]   = pairOn[i]
                                     ? ({cnt_reg[i+1], cnt_reg[i]} == {pri_reg[i+1], pri_reg[i]})
                                     : (cnt_reg[i] == pri_reg[i]);
                    assign mSec[i]   = pairOn[i]
                                     ? ({cnt_reg[i+1], cnt_reg[i]} == {sec_reg[i+1], sec_reg[i]})
                                     : (cnt_reg[i] == sec_reg[i]);
                end else begin : g_single
                    assign pairOn[i] = 1'b0;
                    assign mPri[i]   = (cnt_reg[i] == pri_reg[i]);
                    assign mSec[i]   = (cnt_reg[i] == sec_reg[i]);
                end
                assign follower[i] = 1'b0;
                assign cfgEff[i]   = cfg_reg[i];
                assign step[i]     = tickSel[i] & en[i];
                assign restart[i]  = (syncM[i] & sEvt[i])
                                   | ((cfgEff[i].mode == eoc_pkg::MODE_PWM) & step[i] & mSec[i]);
            end

            // clock source pick
            assign tickSel[i] = (cfgEff[i].clkSel < 3'(eoc_pkg::NUM_CLK_SRC))
                              ? srcTick[cfgEff[i].clkSel] : 1'b0;
            // sync source pick, 1..30, zero is free running
            assign sEvt[i]  = (cfgEff[i].sync != 5'h00) && (cfgEff[i].sync <= 5'(eoc_pkg::NUM_SYNC_SRC))
                            ? syncIn[cfgEff[i].sync - 5'h01] : 1'b0;
            assign trigM[i] = (cfgEff[i].sync != 5'h00) & cfgEff[i].trig;
            assign syncM[i] = (cfgEff[i].sync != 5'h00) & ~cfgEff[i].trig;
            // synchronous and free modes run as soon as a clock and a mode other than off are picked
            assign en[i]    = (cfgEff[i].mode != eoc_pkg::MODE_OFF)
                            & (~trigM[i] | released_reg[i] | sEvt[i]);
            assign carry[i] = step[i] & (cnt_reg[i] == eoc_pkg::CNT_MAX) & ~restart[i];

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cfg_reg[i] <= eoc_pkg::CFG_RESET;
                end else if (regReq.we && unitHit[i] && selReg == eoc_pkg::REG_CON1) begin
                    cfg_reg[i].mode   <= regReq.wdata[eoc_pkg::CON1_MODE_LSB +: 3];
                    cfg_reg[i].clkSel <= regReq.wdata[eoc_pkg::CON1_CLK_LSB +: 3];
                end else if (regReq.we && unitHit[i] && selReg == eoc_pkg::REG_CON2) begin
                    cfg_reg[i].sync <= regReq.wdata[eoc_pkg::CON2_SYNC_LSB +: eoc_pkg::SYNC_W];
                    cfg_reg[i].trig <= regReq.wdata[eoc_pkg::CON2_TRIG_BIT];
                    cfg_reg[i].casc <= regReq.wdata[eoc_pkg::CON2_CASC_BIT];
                end
            end

            // two match registers
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pri_reg[i] <= '0;
                    sec_reg[i] <= '0;
                end else if (regReq.we && unitHit[i]) begin
                    if (selReg == eoc_pkg::REG_PRI) begin
                        pri_reg[i] <= regReq.wdata;
                    end
                    if (selReg == eoc_pkg::REG_SEC) begin
                        sec_reg[i] <= regReq.wdata;
                    end
                end
            end

            // trigger release: event sets, control-two write re-arms, set wins
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    released_reg[i] <= 1'b0;
                end else if (trigM[i] && sEvt[i]) begin
                    released_reg[i] <= 1'b1;
                end else if (regReq.we && unitHit[i] && selReg == eoc_pkg::REG_CON2) begin
                    released_reg[i] <= 1'b0;
                end
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    cnt_reg[i] <= eoc_pkg::CNT_RESET;
                end else if (regReq.we && unitHit[i] && selReg == eoc_pkg::REG_CNT) begin
                    cnt_reg[i] <= regReq.wdata;
                end else if (restart[i]) begin
                    cnt_reg[i] <= eoc_pkg::CNT_RESET;
                end else if (step[i]) begin
                    cnt_reg[i] <= cnt_reg[i] + 16'h0001;
                end
            end

            // match events and waveform; in a cascaded pair, driven by the low unit only
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    evt_reg[i] <= 1'b0;
                end else begin
                    evt_reg[i] <= ~follower[i] & step[i] & (mPri[i] | mSec[i]);
                end
            end

            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    out_reg[i]  <= 1'b0;
                    done_reg[i] <= 1'b0;
                end else if (regReq.we && unitHit[i] && selReg == eoc_pkg::REG_CON1) begin
                    out_reg[i]  <= 1'b0;
                    done_reg[i] <= 1'b0;
                end else if (follower[i]) begin
                    out_reg[i] <= 1'b0;
                end else if (step[i]) begin
                    unique case (cfgEff[i].mode)
                        eoc_pkg::MODE_SINGLE: begin
                            if (!done_reg[i] && mSec[i] && out_reg[i]) begin
                                out_reg[i]  <= 1'b0;
                                done_reg[i] <= 1'b1;
                            end else if (!done_reg[i] && mPri[i]) begin
                                out_reg[i] <= 1'b1;
                            end
                        end
                        eoc_pkg::MODE_CONT: begin
                            if (mSec[i]) begin
                                out_reg[i] <= 1'b0;
                            end else if (mPri[i]) begin
                                out_reg[i] <= 1'b1;
                            end
                        end
                        eoc_pkg::MODE_PWM: begin
                            if (mPri[i]) begin
                                out_reg[i] <= 1'b0;
                            end else if (mSec[i]) begin
                                out_reg[i] <= 1'b1;
                            end
                        end
                        default: begin
                            out_reg[i] <= 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    // read mux, answer one cycle after the strobe
    always_comb begin
        rdata_next = '0;
        if (regReq.re && selUnit < 4'(N)) begin
            unique case (selReg)
                eoc_pkg::REG_CON1: rdata_next = {10'h000, cfg_reg[selUnit].clkSel, cfg_reg[selUnit].mode};
                eoc_pkg::REG_CON2: rdata_next = {7'h00, cfg_reg[selUnit].casc, cfg_reg[selUnit].trig,
                                                 2'h0, cfg_reg[selUnit].sync};
                eoc_pkg::REG_PRI:  rdata_next = pri_reg[selUnit];
                eoc_pkg::REG_SEC:  rdata_next = sec_reg[selUnit];
                eoc_pkg::REG_CNT:  rdata_next = cnt_reg[selUnit];
                eoc_pkg::REG_STAT: rdata_next = {12'h000, pairOn[selUnit], done_reg[selUnit],
                                                 released_reg[selUnit], out_reg[selUnit]};
                default:           rdata_next = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    assign rdata    = rdata_reg;
    assign cmpOut   = out_reg;
    assign cmpEvent = evt_reg;

    logic wr0;
    logic wr1;
    assign wr0 = regReq.we && unitHit[0];
    assign wr1 = regReq.we && unitHit[1];

    property p_count_up;
        @(posedge sys_clk) disable iff (rst)
        (step[0] && !restart[0] && !wr0) |=> (cnt_reg[0] == $past(cnt_reg[0]) + 16'h0001);
    endproperty
    a_count_up: assert property (p_count_up) else $error("counter did not step");

    property p_wrap;
        @(posedge sys_clk) disable iff (rst)
        (step[0] && !restart[0] && !wr0 && cnt_reg[0] == 16'hffff) |=> (cnt_reg[0] == 16'h0000);
    endproperty
    a_wrap: assert property (p_wrap) else $error("counter did not wrap");

    property p_match_evt;
        @(posedge sys_clk) disable iff (rst)
        (step[0] && (mPri[0] || mSec[0])) |=> cmpEvent[0];
    endproperty
    a_match_evt: assert property (p_match_evt) else $error("match gave no event");

    property p_sync_clear;
        @(posedge sys_clk) disable iff (rst)
        (cfg_reg[4].sync != 5'h00 && !cfg_reg[4].trig && !pairOn[4] && sEvt[4] && !(regReq.we && unitHit[4]))
        |=> (cnt_reg[4] == 16'h0000);
    endproperty
    a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear counter");

    property p_trig_hold;
        @(posedge sys_clk) disable iff (rst)
        (trigM[2] && !released_reg[2] && !sEvt[2] && !(regReq.we && unitHit[2]) && !restart[2])
        |=> $stable(cnt_reg[2]);
    endproperty
    a_trig_hold: assert property (p_trig_hold) else $error("armed counter moved");

    property p_casc_carry;
        @(posedge sys_clk) disable iff (rst)
        (pairOn[0] && carry[0] && !wr1) |=> (cnt_reg[1] == $past(cnt_reg[1]) + 16'h0001);
    endproperty
    a_casc_carry: assert property (p_casc_carry) else $error("high half missed carry");

    property p_casc_restart;
        @(posedge sys_clk) disable iff (rst)
        (pairOn[0] && restart[0] && !wr0 && !wr1) |=> (cnt_reg[0] == 16'h0000 && cnt_reg[1] == 16'h0000);
    endproperty
    a_casc_restart: assert property (p_casc_restart) else $error("pair did not restart together");

    property p_pwm_low;
        @(posedge sys_clk) disable iff (rst)
        (cfg_reg[0].mode == eoc_pkg::MODE_PWM && !follower[0] && step[0] && mPri[0] && !wr0) |=> !cmpOut[0];
    endproperty
    a_pwm_low: assert property (p_pwm_low) else $error("pwm stayed high past duty");

    property p_no_clock;
        @(posedge sys_clk) disable iff (rst)
        (!pairOn[5] && cfg_reg[5].clkSel >= 3'h6 && !(regReq.we && unitHit[5]) && !restart[5])
        |=> $stable(cnt_reg[5]);
    endproperty
    a_no_clock: assert property (p_no_clock) else $error("counter ran without a source");

    property p_free_run;
        @(posedge sys_clk) disable iff (rst)
        (cfg_reg[7].sync == 5'h00 && cfg_reg[7].mode == eoc_pkg::MODE_CONT && cfg_reg[7].clkSel == 3'h0
         && !pairOn[7] && !(regReq.we && unitHit[7])) |=> (cnt_reg[7] == $past(cnt_reg[7]) + 16'h0001);
    endproperty
    a_free_run: assert property (p_free_run) else $error("free running counter stalled");

    property p_sync_other;
        @(posedge sys_clk) disable iff (rst)
        (syncM[4] && !sEvt[4] && step[4] && cfgEff[4].mode != eoc_pkg::MODE_PWM && !(regReq.we && unitHit[4]))
        |=> (cnt_reg[4] == $past(cnt_reg[4]) + 16'h0001);
    endproperty
    a_sync_other: assert property (p_sync_other) else $error("unselected line touched counter");

    property p_trig_release;
        @(posedge sys_clk) disable iff (rst)
        (trigM[2] && sEvt[2]) |=> released_reg[2];
    endproperty
    a_trig_release: assert property (p_trig_release) else $error("trigger event did not release");

    property p_follower_quiet;
        @(posedge sys_clk) disable iff (rst)
        follower[1] |=> (!cmpEvent[1] && !cmpOut[1]);
    endproperty
    a_follower_quiet: assert property (p_follower_quiet) else $error("high half drove an output");

    property p_single_once;
        @(posedge sys_clk) disable iff (rst)
        (cfg_reg[0].mode == eoc_pkg::MODE_SINGLE && !follower[0] && done_reg[0] && !wr0) |=> !cmpOut[0];
    endproperty
    a_single_once: assert property (p_single_once) else $error("single pulse repeated");
endmodule

// file: eoc_pkg.sv
package eoc_pkg;
    localparam int NUM_UNITS    = 9;
    localparam int CNT_W        = 16;
    localparam int DATA_W       = 16;
    localparam int ADDR_W       = 7;
    localparam int UNIT_LSB     = 3;
    localparam int NUM_CLK_SRC  = 6;
    localparam int NUM_SYNC_SRC = 30;
    localparam int SYNC_W       = 5;
    localparam int DIV_W        = 6;

    // register index inside a unit's block of eight words
    localparam logic [2:0] REG_CON1 = 3'h0;
    localparam logic [2:0] REG_CON2 = 3'h1;
    localparam logic [2:0] REG_PRI  = 3'h2;
    localparam logic [2:0] REG_SEC  = 3'h3;
    localparam logic [2:0] REG_CNT  = 3'h4;
    localparam logic [2:0] REG_STAT = 3'h5;

    // field positions
    localparam int CON1_MODE_LSB = 0;
    localparam int CON1_CLK_LSB  = 3;
    localparam int CON2_SYNC_LSB = 0;
    localparam int CON2_TRIG_BIT = 7;
    localparam int CON2_CASC_BIT = 8;

    // output modes
    localparam logic [2:0] MODE_OFF    = 3'h0;
    localparam logic [2:0] MODE_SINGLE = 3'h1;
    localparam logic [2:0] MODE_CONT   = 3'h2;
    localparam logic [2:0] MODE_PWM    = 3'h3;

    localparam logic [CNT_W-1:0] CNT_MAX   = 16'hffff;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;

    typedef struct packed {
        logic              casc;
        logic              trig;
        logic [SYNC_W-1:0] sync;
        logic [2:0]        clkSel;
        logic [2:0]        mode;
    } eoc_cfg_s;

    localparam eoc_cfg_s CFG_RESET = '0;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic              we;
        logic              re;
    } eoc_req_s;
endpackage

module eoc_clock_sources (
    input  wire logic                              sys_clk,
    input  wire logic                              rst,
    input  wire logic [1:0]                        extClkPin,
    output logic      [eoc_pkg::NUM_CLK_SRC-1:0]   srcTick
);
    logic [eoc_pkg::DIV_W-1:0] divCnt_reg;
    logic [1:0]                sync1_reg;
    logic [1:0]                sync2_reg;
    logic [1:0]                prev_reg;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divCnt_reg <= '0;
        end else begin
            divCnt_reg <= divCnt_reg + 6'h01;
        end
    end

    // pins pass two flops, edge taken after the second
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            prev_reg  <= 2'h0;
        end else begin
            sync1_reg <= extClkPin;
            sync2_reg <= sync1_reg;
            prev_reg  <= sync2_reg;
        end
    end

    assign srcTick[0] = 1'b1;
    assign srcTick[1] = (divCnt_reg[1:0] == 2'h3);
    assign srcTick[2] = (divCnt_reg[3:0] == 4'hf);
    assign srcTick[3] = (divCnt_reg == 6'h3f);
    assign srcTick[4] = sync2_reg[0] & ~prev_reg[0];
    assign srcTick[5] = sync2_reg[1] & ~prev_reg[1];
endmodule

// file: enhanced_output_compare_unit_tb.sv
module enhanced_output_compare_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  sysClk = 1'b0;
    logic                  rst = 1'b1;
    eoc_pkg::eoc_req_s     regReq = '0;
    logic [15:0]           rdata;
    logic [29:0]           syncIn = '0;
    logic [1:0]            extClkPin = '0;
    logic [8:0]            cmpOut;
    logic [8:0]            cmpEvent;
    int                    mismatches = 0;
    int                    num_checks = 0;
    int                    cycles = 0;
    int                    hiCnt = 0;
    int                    evCnt = 0;
    logic [31:0]           rngState = 32'h6;

    eoc_top eoc_top_i (
        .sys_clk  (sysClk),
        .rst      (rst),
        .regReq   (regReq),
        .rdata    (rdata),
        .syncIn   (syncIn),
        .extClkPin(extClkPin),
        .cmpOut   (cmpOut),
        .cmpEvent (cmpEvent)
    );

    always #2 sysClk = ~sysClk;

    // waveform statistics of unit 0, taken where outputs are settled
    always @(negedge sysClk) begin
        if (cmpOut[0] === 1'b1) hiCnt++;
        if (cmpEvent[0] === 1'b1) evCnt++;
    end

    always @(posedge sysClk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            $display("mismatch timeout expected 0 seen 1");
            results();
        end
    end

    function automatic logic [31:0] xs();
        logic [31:0] x;
        x = rngState;
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        rngState = x;
        return x;
    endfunction

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic tick(int n);
        repeat (n) @(posedge sysClk);
    endtask

    // one write cycle, then one idle cycle so strobes never merge
    task automatic wr(logic [3:0] unit, logic [2:0] idx, logic [15:0] d);
        regReq.addr  <= {unit, idx};
        regReq.wdata <= d;
        regReq.we    <= 1'b1;
        @(posedge sysClk);
        regReq.we <= 1'b0;
        @(posedge sysClk);
    endtask

    task automatic rd(logic [3:0] unit, logic [2:0] idx, output logic [15:0] v);
        regReq.addr <= {unit, idx};
        regReq.re   <= 1'b1;
        @(posedge sysClk);
        regReq.re <= 1'b0;
        @(negedge sysClk);
        v = rdata;
        @(posedge sysClk);
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        logic [15:0] v;
        logic [15:0] a;
        int          sec;
        int          pri;
        int          h0;
        int          e0;
        int          e;
        tick(12);
        rst <= 1'b0;
        @(posedge sysClk);
        rd(4'h0, eoc_pkg::REG_CON1, v); check("con1 reset", v, 32'h0);
        rd(4'h0, eoc_pkg::REG_CON2, v); check("con2 reset", v, 32'h0);
        wr(4'h9, 3'h0, 16'h0003);
        rd(4'h9, 3'h0, v); check("unmapped unit", v, 32'h0);
        rd(4'h0, 3'h6, v); check("unmapped index 6", v, 32'h0);
        rd(4'h0, 3'h7, v); check("unmapped index 7", v, 32'h0);
        // free running count and wrap from ffff to 0000
        wr(4'h7, eoc_pkg::REG_CON1, 16'h0002);
        wr(4'h7, eoc_pkg::REG_CNT, 16'h1234);
        rd(4'h7, eoc_pkg::REG_CNT, v); check("count", v, 32'h1235);
        rd(4'h7, eoc_pkg::REG_CNT, v); check("count", v, 32'h1237);
        wr(4'h7, eoc_pkg::REG_CNT, 16'hfffe);
        rd(4'h7, eoc_pkg::REG_CNT, v); check("wrap", v, 32'hffff);
        rd(4'h7, eoc_pkg::REG_CNT, v); check("wrap", v, 32'h0001);
        wr(4'h8, eoc_pkg::REG_CNT, 16'h0007);
        tick(5);
        rd(4'h8, eoc_pkg::REG_CNT, v); check("idle unit", v, 32'h0007);
        // synchronous mode: only the selected line clears the counter
        wr(4'h4, eoc_pkg::REG_CON1, 16'h0002);
        wr(4'h4, eoc_pkg::REG_CON2, 16'h0005);
        wr(4'h4, eoc_pkg::REG_CNT, 16'h0100);
        syncIn[5] <= 1'b1;
        @(posedge sysClk);
        syncIn[5] <= 1'b0;
        rd(4'h4, eoc_pkg::REG_CNT, v); check("sync other line", v, 32'h0102);
        syncIn[4] <= 1'b1;
        @(posedge sysClk);
        syncIn[4] <= 1'b0;
        rd(4'h4, eoc_pkg::REG_CNT, v); check("sync clear", v, 32'h0);
        // trigger mode: counter held until the selected line fires
        wr(4'h2, eoc_pkg::REG_CON2, 16'h0083);
        wr(4'h2, eoc_pkg::REG_CON1, 16'h0002);
        tick(6);
        rd(4'h2, eoc_pkg::REG_CNT, v); check("trigger held", v, 32'h0);
        syncIn[3] <= 1'b1;
        @(posedge sysClk);
        syncIn[3] <= 1'b0;
        rd(4'h2, eoc_pkg::REG_CNT, v); check("trigger other line", v, 32'h0);
        syncIn[2] <= 1'b1;
        @(posedge sysClk);
        syncIn[2] <= 1'b0;
        rd(4'h2, eoc_pkg::REG_CNT, a); check("trigger start", 32'(a < 2), 32'h1);
        rd(4'h2, eoc_pkg::REG_CNT, v); check("trigger run", v - a, 32'h2);
        // pwm with random period and duty on unit 0
        repeat (3) begin
            sec = 3 + int'(xs() % 16);
            pri = 1 + int'(xs() % 32'(sec - 1));
            wr(4'h0, eoc_pkg::REG_PRI, 16'(pri));
            wr(4'h0, eoc_pkg::REG_SEC, 16'(sec));
            wr(4'h0, eoc_pkg::REG_CNT, 16'h0);
            wr(4'h0, eoc_pkg::REG_CON1, 16'h0003);
            rd(4'h0, eoc_pkg::REG_PRI, v); check("primary", v, 32'(pri));
            tick(3 * (sec + 1));
            h0 = hiCnt;
            e0 = evCnt;
            tick(8 * (sec + 1));
            check("pwm high", hiCnt - h0, 32'(8 * (pri + 1)));
            check("pwm events", evCnt - e0, 32'(16));
        end
        // single pulse against continuous pulses
        for (int m = 1; m <= 2; m++) begin
            wr(4'h0, eoc_pkg::REG_CON1, 16'h0);
            wr(4'h0, eoc_pkg::REG_PRI, 16'h0005);
            wr(4'h0, eoc_pkg::REG_SEC, 16'h000a);
            wr(4'h0, eoc_pkg::REG_CNT, 16'h0);
            h0 = hiCnt;
            e0 = evCnt;
            wr(4'h0, eoc_pkg::REG_CON1, 16'(m));
            tick(30);
            wr(4'h0, eoc_pkg::REG_CNT, 16'hfff0);
            tick(40);
            check("pulse high", hiCnt - h0, 32'(5 * m));
            if (m == 2) check("pulse events", evCnt - e0, 32'(4));
        end
        // cascade needs the bit in both units
        wr(4'h0, eoc_pkg::REG_CON1, 16'h0002);
        for (int b = 0; b < 2; b++) begin
            wr(4'h0, eoc_pkg::REG_CON2, 16'h0101);
            wr(4'h1, eoc_pkg::REG_CON2, b ? 16'h0100 : 16'h0);
            wr(4'h1, eoc_pkg::REG_CNT, 16'h0005);
            wr(4'h0, eoc_pkg::REG_CNT, 16'hfffe);
            tick(4);
            rd(4'h1, eoc_pkg::REG_CNT, v); check("high half", v, 32'(5 + b));
            rd(4'h0, eoc_pkg::REG_CNT, v); check("low half", 32'(v < 16), 32'h1);
        end
        syncIn[0] <= 1'b1;
        @(posedge sysClk);
        syncIn[0] <= 1'b0;
        rd(4'h1, eoc_pkg::REG_CNT, v); check("pair restart", v, 32'h0);
        // divided clock sources
        for (int s = 1; s <= 3; s++) begin
            wr(4'h3, eoc_pkg::REG_CON1, 16'((s << 3) | 2));
            wr(4'h3, eoc_pkg::REG_CNT, 16'h0);
            tick(128);
            rd(4'h3, eoc_pkg::REG_CNT, v);
            e = 129 / (4 << (2 * (s - 1)));
            check("divided source", 32'(int'(v) >= e - 1 && int'(v) <= e + 1), 32'h1);
        end
        // pin clock sources
        for (int k = 0; k < 2; k++) begin
            wr(4'h5, eoc_pkg::REG_CON1, 16'(((4 + k) << 3) | 2));
            wr(4'h5, eoc_pkg::REG_CNT, 16'h0);
            repeat (7) begin
                extClkPin[k] <= 1'b1;
                tick(4);
                extClkPin[k] <= 1'b0;
                tick(4);
            end
            tick(4);
            rd(4'h5, eoc_pkg::REG_CNT, v); check("pin source", v, 32'h7);
        end
        // source codes above five give no ticks
        wr(4'h5, eoc_pkg::REG_CON1, 16'h0032);
        wr(4'h5, eoc_pkg::REG_CNT, 16'h0009);
        tick(8);
        rd(4'h5, eoc_pkg::REG_CNT, v); check("no source", v, 32'h9);
        results();
    end
endmodule
